//--- rtl/bsr_pkg.sv
// Shared constants and types for the burst memory read port
package bsr_pkg;
	localparam int WORD_W      = 18;
	localparam int BURST_LEN   = 4;
	localparam int LINE_W      = WORD_W * BURST_LEN;
	localparam int ADDR_W      = 20;
	localparam int ARRAY_DEPTH = 1 << ADDR_W;
	localparam int FIFO_DEPTH  = 16;
	localparam int SYNC_STAGES = 2;
	localparam logic [WORD_W-1:0] WORD_RESET = 18'h00000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;

	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [LINE_W-1:0] data;
	} bsr_load_t;

	localparam int LOAD_W = $bits(bsr_load_t);
endpackage

//--- rtl/bsr_fifo.sv
// Single-clock FIFO with valid/ready on both sides
module bsr_fifo #(
	parameter int WIDTH = 92,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = PTR_W + 1;
	localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

	logic [WIDTH-1:0] slots [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (count != '0);
	assign out_data  = slots[rd_ptr];

	always_comb
	begin
		next_count = count;
		if (push && !pop)
			next_count = count + CNT_W'(1);
		else if (pop && !push)
			next_count = count - CNT_W'(1);
	end

	always_ff @(posedge clock)
	begin
		if (push)
			slots[wr_ptr] <= in_data;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			count    <= '0;
			in_ready <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + PTR_W'(1);
			if (pop)
				rd_ptr <= rd_ptr + PTR_W'(1);
			count    <= next_count;
			// Registered so the source sees a clean flop
			in_ready <= (next_count < FULL_COUNT);
		end
	end
endmodule

//--- rtl/bsr_read_port.sv
// Burst memory read port: link-clocked DDR read path over a system-clocked array
//
// Function
// - Read starts at positive clock rise, select low
// - Capture shared address into read address register
// - Lowest word appears after two positive rises, one with loop disabled
// - Later words alternate clocks until four sent
// - Burst takes two cycles, no consecutive starts
// - Read request right after start is ignored
// - Alternate starts keep output pipeline full
// - Deselect finishes bursts, then outputs released
// - Loop enabled gives two cycle latency
// - Loop disabled gives one cycle latency
// - Requests recognised only on positive clock rise
// - Selects registered on input clock rises
// - Data bits driven from clocked output registers
// - Storage is four arrays of 1M words
// - Valid flag leads data by half cycle
// - Two free-running echo clocks follow inputs
module bsr_read_port
	import bsr_pkg::*;
(
	input  wire logic                      clock,
	input  wire logic                      srst,
	input  wire bsr_pkg::bsr_load_t        load,
	input  wire logic                      load_valid,
	output logic                           load_ready,
	input  wire logic                      k,
	input  wire logic                      k_n,
	input  wire logic                      read_port_select_n,
	input  wire logic [bsr_pkg::ADDR_W-1:0] address,
	input  wire logic                      loop_disable_n,
	output logic      [bsr_pkg::WORD_W-1:0] read_data,
	output logic                           read_data_oe,
	output logic                           read_valid_flag,
	output logic                           echo_clock,
	output logic                           echo_clock_n
);
	import bsr_pkg::*;

	// Link-side state
	logic                k_rst_s1;
	logic                k_rst;
	logic                dll_s1;
	logic                lat2;
	logic                accept;
	logic                start;
	logic [1:0]          stage;
	logic                first;
	logic                second;
	logic [ADDR_W-1:0]   rd_addr;
	logic                req_tog;
	logic                cur_sel;
	logic                drv0;
	logic                drv2;
	logic [WORD_W-1:0]   q_k;
	logic                oe_k;
	logic                valid_k;
	logic [WORD_W-1:0]   q_kn;
	logic                oe_kn;
	logic                valid_kn;
	logic [LINE_W-1:0]   line_new;
	logic [LINE_W-1:0]   line_cur;

	// System-side state
	logic                req_s1;
	logic                req_s2;
	logic                req_s3;
	logic                rd_go;
	logic [LINE_W-1:0]   line_buf0;
	logic [LINE_W-1:0]   line_buf1;
	logic                fifo_out_valid;
	logic [LOAD_W-1:0]   fifo_out_data;
	bsr_load_t           wr_entry;
	logic                mem_wr;

	// Reset reaches the link side through two flops
	always_ff @(posedge k)
	begin
		k_rst_s1 <= srst;
		k_rst    <= k_rst_s1;
	end

	// Mode pin is static but asynchronous to the link
	always_ff @(posedge k)
	begin
		dll_s1 <= loop_disable_n;
		lat2   <= dll_s1;
	end

	// A start blocks the very next rise
	assign accept = !read_port_select_n && !start;

	always_ff @(posedge k)
	begin
		if (k_rst)
			start <= 1'b0;
		else
			start <= accept;
	end

	always_ff @(posedge k)
	begin
		if (k_rst)
			stage <= 2'b00;
		else
			stage <= {stage[0], start};
	end

	// Held until the next start, at least two link cycles
	always_ff @(posedge k)
	begin
		if (k_rst)
			rd_addr <= ADDR_RESET;
		else if (accept)
			rd_addr <= address;
	end

	always_ff @(posedge k)
	begin
		if (k_rst)
			req_tog <= 1'b0;
		else if (accept)
			req_tog <= !req_tog;
	end

	assign first  = lat2 ? stage[0] : start;
	assign second = lat2 ? stage[1] : stage[0];

	// Line buffer is chosen by request parity so back-to-back bursts never collide
	assign line_new = req_tog ? line_buf1 : line_buf0;
	assign line_cur = cur_sel ? line_buf1 : line_buf0;

	always_ff @(posedge k)
	begin
		if (k_rst)
		begin
			cur_sel <= 1'b0;
			drv0    <= 1'b0;
			drv2    <= 1'b0;
			oe_k    <= 1'b0;
			valid_k <= 1'b0;
			q_k     <= WORD_RESET;
		end
		else
		begin
			if (first)
				cur_sel <= req_tog;
			drv0    <= first;
			drv2    <= second;
			oe_k    <= first || second;
			valid_k <= first || second;
			if (first)
				q_k <= line_new[0 +: WORD_W];
			else if (second)
				q_k <= line_cur[2*WORD_W +: WORD_W];
		end
	end

	always_ff @(posedge k_n)
	begin
		if (k_rst)
		begin
			oe_kn    <= 1'b0;
			valid_kn <= 1'b0;
			q_kn     <= WORD_RESET;
		end
		else
		begin
			oe_kn    <= oe_k;
			// Rises half a cycle ahead of the first word
			valid_kn <= lat2 ? (stage[0] || stage[1]) : (start || stage[0]);
			if (drv0)
				q_kn <= line_cur[WORD_W +: WORD_W];
			else if (drv2)
				q_kn <= line_cur[3*WORD_W +: WORD_W];
		end
	end

	// DDR pin: each half cycle shows the flop of the clock that launched it
	assign read_data       = k ? q_k : q_kn;
	assign read_data_oe    = k ? oe_k : oe_kn;
	assign read_valid_flag = k ? valid_k : valid_kn;
	assign echo_clock      = k;
	assign echo_clock_n    = k_n;

	// Request toggle crosses into the system clock
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end
		else
		begin
			req_s1 <= req_tog;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	assign rd_go = req_s2 ^ req_s3;

	// Starts are two link cycles apart, so each toggle arrives as a lone pulse
	chk_go_single: assert property (@(posedge clock) disable iff (srst)
		rd_go |=> (!rd_go) [*8])
		else $error("read request pulse too long");

	// Preload path; reads take the array first, loads wait
	bsr_fifo #(
		.WIDTH (LOAD_W),
		.DEPTH (FIFO_DEPTH)
	) u_load_fifo (
		.clock     (clock),
		.srst      (srst),
		.in_valid  (load_valid),
		.in_ready  (load_ready),
		.in_data   (load),
		.out_valid (fifo_out_valid),
		.out_ready (!rd_go),
		.out_data  (fifo_out_data)
	);

	assign wr_entry = fifo_out_data;
	assign mem_wr   = fifo_out_valid && !rd_go;

	for (genvar i = 0; i < BURST_LEN; i++)
	begin : g_array
		logic [WORD_W-1:0] cells [ARRAY_DEPTH];
		logic [WORD_W-1:0] hold  [2];

		always_ff @(posedge clock)
		begin
			if (mem_wr)
				cells[wr_entry.addr] <= wr_entry.data[i*WORD_W +: WORD_W];
		end

		// rd_addr is stable here: it only moves on the next accepted read
		always_ff @(posedge clock)
		begin
			if (rd_go)
				hold[req_s2] <= cells[rd_addr];
		end

		assign line_buf0[i*WORD_W +: WORD_W] = hold[0];
		assign line_buf1[i*WORD_W +: WORD_W] = hold[1];
	end

	sequence s_start;
		start;
	endsequence

	sequence s_back_to_back;
		start ##2 (start && lat2);
	endsequence

	chk_second_ignored: assert property (@(posedge k) disable iff (k_rst)
		s_start |=> !start)
		else $error("read accepted on consecutive rise");

	chk_addr_capture: assert property (@(posedge k) disable iff (k_rst)
		s_start |-> (rd_addr == $past(address)))
		else $error("read address not captured");

	chk_dll_latency: assert property (@(posedge k) disable iff (k_rst)
		(s_start and lat2) |-> ##1 first ##1 (drv0 && oe_k))
		else $error("two cycle latency violated");

	chk_legacy_latency: assert property (@(posedge k) disable iff (k_rst)
		(s_start and !lat2) |-> first ##1 (drv0 && oe_k))
		else $error("one cycle latency violated");

	chk_word_order: assert property (@(posedge k) disable iff (k_rst)
		drv0 |-> (drv2 == 1'b0) ##1 (drv2 && oe_k))
		else $error("third word did not follow first");

	chk_word0_data: assert property (@(posedge k) disable iff (k_rst)
		first |=> (q_k == $past(line_new[0 +: WORD_W])))
		else $error("lowest word wrong");

	chk_odd_words: assert property (@(posedge k_n) disable iff (k_rst)
		drv0 |=> (q_kn == $past(line_cur[WORD_W +: WORD_W])))
		else $error("second word wrong on negative clock");

	chk_valid_lead: assert property (@(posedge k) disable iff (k_rst)
		first |-> valid_kn)
		else $error("valid flag not half cycle early");

	chk_output_release: assert property (@(posedge k) disable iff (k_rst)
		(!first && !second) |=> !oe_k)
		else $error("outputs not released after burst");

	chk_pipe_full: assert property (@(posedge k) disable iff (k_rst)
		s_back_to_back |-> oe_k [*4])
		else $error("pipeline gap on alternate reads");

	sequence s_deselected;
		read_port_select_n [*3];
	endsequence

	sequence s_alternate_legacy;
		start ##2 (start && !lat2);
	endsequence

	chk_start_toggles: assert property (@(posedge k) disable iff (k_rst)
		s_start |-> (req_tog != $past(req_tog)))
		else $error("accepted read sent no request");

	chk_ignored_quiet: assert property (@(posedge k) disable iff (k_rst)
		!start |-> $stable(req_tog))
		else $error("request sent without accepted read");

	chk_addr_held: assert property (@(posedge k) disable iff (k_rst)
		!start |-> $stable(rd_addr))
		else $error("read address moved mid burst");

	chk_deselect_idle: assert property (@(posedge k) disable iff (k_rst)
		s_deselected |-> ##2 (!oe_k && !valid_k))
		else $error("outputs still driven after deselect");

	chk_link_reset: assert property (@(posedge k)
		k_rst |=> (!oe_k && !valid_k))
		else $error("outputs driven during reset");

	chk_word2_data: assert property (@(posedge k) disable iff (k_rst)
		second |=> (q_k == $past(line_cur[2*WORD_W +: WORD_W])))
		else $error("third word wrong");

	chk_word3_data: assert property (@(posedge k_n) disable iff (k_rst)
		drv2 |=> (q_kn == $past(line_cur[3*WORD_W +: WORD_W])))
		else $error("fourth word wrong on negative clock");

	chk_odd_enable: assert property (@(posedge k_n) disable iff (k_rst)
		(drv0 || drv2) |=> oe_kn)
		else $error("negative clock word not driven");

	chk_valid_then_data: assert property (@(posedge k_n) disable iff (k_rst)
		$rose(valid_kn) |-> oe_k)
		else $error("data missing after valid flag");

	chk_pipe_legacy: assert property (@(posedge k) disable iff (k_rst)
		s_alternate_legacy |-> oe_k [*3])
		else $error("pipeline gap on alternate legacy reads");
endmodule

//--- test/bsr_ctrl_model.sv
// Controller model: link clocks, read select and address
module bsr_ctrl_model
	import bsr_pkg::*;
(
	input  wire logic                       go,
	input  wire logic [bsr_pkg::ADDR_W-1:0] go_addr,
	output logic                            k,
	output logic                            k_n,
	output logic                            read_port_select_n,
	output logic      [bsr_pkg::ADDR_W-1:0] address
);
	timeunit 1ns;
	timeprecision 100ps;

	// 8 MHz, far under the unlocked-loop ceiling
	initial
	begin
		k = 1'b0;
		read_port_select_n = 1'b1;
		address = 20'h00000;
		#3.3;
		forever
			#62.5 k = ~k;
	end

	assign k_n = ~k;

	// Idle address inverted so a stale value never reads as valid
	always @(posedge k)
	begin
		#1;
		read_port_select_n = ~go;
		address = go ? go_addr : ~address;
	end
endmodule

//--- test/test_bsr_read_port.sv
// Self-checking bench for the burst memory read port
module test_bsr_read_port;
	timeunit 1ns;
	timeprecision 100ps;
	import bsr_pkg::*;

	logic             clock = 1'b0;
	logic             srst = 1'b1;
	bsr_load_t        load = '0;
	logic             load_valid = 1'b0;
	logic             load_ready, k, k_n, sel_n, oe, vld, ec, ec_n;
	logic             go = 1'b0;
	logic             loop_disable_n = 1'b1;
	logic [19:0]      adr = 20'h00000;
	logic [19:0]      address;
	logic [17:0]      read_data;
	logic [71:0]      mem [logic [19:0]];
	logic [17:0]      qw [$];
	int               qh [$];
	int               hc = 0;
	int               lat = 2;
	int               n_mismatch = 0;
	int               checked = 0;
	logic             pv = 1'b0;

	bsr_read_port bsr_read_port_i (.clock(clock), .srst(srst), .load(load), .load_valid(load_valid),
		.load_ready(load_ready), .k(k), .k_n(k_n), .read_port_select_n(sel_n), .address(address),
		.loop_disable_n(loop_disable_n), .read_data(read_data), .read_data_oe(oe),
		.read_valid_flag(vld), .echo_clock(ec), .echo_clock_n(ec_n));

	bsr_ctrl_model bsr_ctrl_model_i (.go(go), .go_addr(adr), .k(k), .k_n(k_n),
		.read_port_select_n(sel_n), .address(address));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Held over from one call to the next so loads go back to back
	task automatic ld(input logic [19:0] a, input logic [71:0] dd);
		int t;
		load = {a, dd};
		load_valid = 1'b1;
		for (t = 0; t < 50 && load_ready !== 1'b1; t++)
			@(negedge clock);
		if (t == 50)
			chk(32'h0, 32'h1);
		@(negedge clock);
	endtask

	task automatic rd(input logic [19:0] a, input int dup);
		int j;
		@(posedge k);
		#10;
		go = 1'b1;
		adr = a;
		for (j = 0; j < 4; j++)
		begin
			qw.push_back(mem[a][18*j +: 18]);
			// Model shows go at the next rise, port samples it one rise later: start is four halves on
			qh.push_back(hc + 4 + 2 * lat + j);
		end
		repeat (dup + 1) @(posedge k);
		#10;
		go = 1'b0;
	endtask

	task automatic drain;
		int t;
		for (t = 0; t < 40 && qw.size() != 0; t++)
			@(posedge k);
		if (qw.size() != 0)
			chk(qw.size(), 32'h0);
		repeat (2) @(posedge k);
	endtask

	initial
	begin
		forever
			#4 clock = ~clock;
	end

	initial
	begin
		#100000;
		n_mismatch++;
		complete_run();
	end

	// Word expected on the half after the valid flag was seen
	always @(posedge k or posedge k_n)
	begin
		hc++;
		#5;
		if (!srst)
		begin
			if (pv)
			begin
				if (qw.size() == 0)
					chk(32'h1, 32'h0);
				else
				begin
					chk(read_data, qw[0]);
					chk(hc, qh[0]);
					void'(qw.pop_front());
					void'(qh.pop_front());
				end
			end
			chk(oe, pv);
			chk(ec, k);
			chk(ec_n, !k);
			pv = vld;
		end
	end

	initial
	begin
		int i;
		int j;
		int m;
		logic [15:0] r;
		logic [71:0] d;
		logic [19:0] ad [8];
		repeat (8) @(negedge clock);
		repeat (3) @(posedge k);
		@(negedge clock);
		srst = 1'b0;
		r = 16'h8AE8;
		for (i = 0; i < 8; i++)
		begin
			r = lfsr(r);
			ad[i] = (i == 7) ? 20'hFFFFF : {r[3:0], r};
			for (j = 0; j < 4; j++)
			begin
				r = lfsr(r);
				d[18*j +: 18] = {r[1:0], r};
			end
			mem[ad[i]] = d;
			ld(ad[i], d);
		end
		load_valid = 1'b0;
		for (m = 0; m < 2; m++)
		begin
			@(negedge clock);
			loop_disable_n = (m == 0);
			lat = 2 - m;
			repeat (3) @(posedge k);
			for (i = 0; i < 8; i++)
				rd(ad[i], 0);
			rd(ad[1], 1);
			rd(ad[2], 0);
			drain();
		end
		complete_run();
	end
endmodule
